// [include/csch_pkg.sv]
// shared constants for the cell-rate shaper scheduler
package csch_pkg;
   localparam int PASS_CLKS = 36;
   localparam int NSH = 16;
   localparam int SH_W = 4;
   localparam int VC_W = 15;
   localparam int VC_IDX_W = 6;
   localparam int NVC = 64;
   localparam int XY_W = 32;
   localparam int CNT_W = 8;
   localparam int PRIO_W = 4;
   localparam int WORD_W = 32;
   localparam int PASS_W = 6;
   // pointer entry layout
   localparam int SPE_ACT_BIT = 31;
   localparam int SPE_UCG_BIT = 30;
   localparam int SPE_VC_MSB = 14;
   localparam logic [WORD_W-1:0] SPE_RESET = 32'h0000_0000;
   // parameter write field selectors
   localparam logic [2:0] FLD_I = 3'h0;
   localparam logic [2:0] FLD_M = 3'h1;
   localparam logic [2:0] FLD_P = 3'h2;
   localparam logic [2:0] FLD_C = 3'h3;
   localparam logic [2:0] FLD_PRIO = 3'h4;
   localparam logic [2:0] FLD_CTRL = 3'h5;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ACT_BIT = 1;
endpackage

// [core/csch_pass_timer.sv]
// pass divider: one-cycle tick at the last clock of each pass
`timescale 1ns/1ps
module csch_pass_timer #(
   parameter int LEN = 36
) (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, active high
   output logic tick, // last cycle of the pass
   output logic pre_tick // cycle before the tick
);
   logic [csch_pkg::PASS_W-1:0] cnt;
   logic [csch_pkg::PASS_W-1:0] next_cnt;
   localparam logic [csch_pkg::PASS_W-1:0] LAST = csch_pkg::PASS_W'(LEN - 1);
   localparam logic [csch_pkg::PASS_W-1:0] PRE = csch_pkg::PASS_W'(LEN - 2);
   localparam logic [csch_pkg::PASS_W-1:0] ONE = csch_pkg::PASS_W'(1);

   always_comb
   begin
      next_cnt = (cnt == LAST) ? '0 : cnt + ONE;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign tick = (cnt == LAST);
   assign pre_tick = (cnt == PRE);
endmodule

// [core/csch_scheduler.sv]
// shaper scheduler: leaky buckets, shaper selection, VC list upkeep
// ---------------------------------------------
// Summary of operation
// ---------------------------------------------
`timescale 1ns/1ps
module csch_scheduler (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic all_shapers_on, // global shaper enable
   input wire logic go_valid, // transmit-go command strobe
   input wire logic [csch_pkg::VC_W-1:0] go_vc, // VC named by transmit-go
   input wire logic [csch_pkg::SH_W-1:0] go_shaper, // shaper number from VC table
   input wire logic done_valid, // VC descriptor vacant, data all read
   input wire logic [csch_pkg::VC_W-1:0] done_vc, // VC that went idle
   input wire logic acc_valid, // indirect access strobe
   input wire logic acc_write, // 1 write, 0 read
   input wire logic [csch_pkg::SH_W-1:0] acc_index, // pointer entry index
   input wire logic [csch_pkg::WORD_W-1:0] acc_wdata, // entry write data
   input wire logic prm_valid, // scheduler parameter write strobe
   input wire logic [csch_pkg::SH_W-1:0] prm_shaper, // shaper written
   input wire logic [2:0] prm_field, // field selector
   input wire logic [csch_pkg::WORD_W-1:0] prm_wdata, // field value
   output logic cmd_ready, // commands taken this cycle
   output logic [csch_pkg::WORD_W-1:0] acc_rdata, // entry read data
   output logic acc_rvalid, // read data valid
   output logic sel_valid, // data cell for sel_vc this slot
   output logic sel_idle, // unassigned or idle cell this slot
   output logic [csch_pkg::VC_W-1:0] sel_vc, // VC to transmit
   output logic [csch_pkg::SH_W-1:0] sel_shaper, // shaper serving the slot
   output logic [csch_pkg::NSH-1:0] scan_flags // scan flag per shaper
);
   localparam int N = csch_pkg::NSH;
   localparam int NV = csch_pkg::NVC;
   localparam logic [csch_pkg::CNT_W-1:0] C_ONE = 8'h01;

   logic tick;
   logic pre_tick;

   // ---------------------------------------------
   // shaper and VC table state
   // ---------------------------------------------
   logic [csch_pkg::XY_W-1:0] x [N], next_x [N], y [N], next_y [N];
   logic [csch_pkg::XY_W-1:0] pi [N], next_pi [N], pm [N], next_pm [N];
   logic [csch_pkg::CNT_W-1:0] c [N], next_c [N], p [N], next_p [N];
   logic [csch_pkg::CNT_W-1:0] pp [N], next_pp [N], pc [N], next_pc [N];
   logic [csch_pkg::PRIO_W-1:0] prio [N], next_prio [N];
   logic [N-1:0] en, next_en, act, next_act, rr, next_rr, next_scan;
   logic [N-1:0] spe_a, next_spe_a, spe_u, next_spe_u;
   logic [csch_pkg::VC_W-1:0] spe_vc [N], next_spe_vc [N];
   logic [csch_pkg::VC_IDX_W-1:0] tail [N], next_tail [N];
   logic [csch_pkg::VC_IDX_W-1:0] fwd [NV], next_fwd [NV], bwd [NV], next_bwd [NV];
   logic [NV-1:0] vc_act, next_vc_act;
   logic [csch_pkg::SH_W-1:0] vc_sh [NV], next_vc_sh [NV];
   logic next_cmd_ready, next_rvalid, next_sel_valid, next_sel_idle;
   logic [csch_pkg::WORD_W-1:0] next_rdata;
   logic [csch_pkg::VC_W-1:0] next_sel_vc;
   logic [csch_pkg::SH_W-1:0] next_sel_shaper;

   csch_pass_timer #(.LEN(csch_pkg::PASS_CLKS)) u_timer (
      .clk(clk),
      .srst(srst),
      .tick(tick),
      .pre_tick(pre_tick)
   );

   always_comb
   begin
      logic [N-1:0] elig;
      logic [N-1:0] tied;
      logic [csch_pkg::PRIO_W-1:0] best;
      logic found;
      logic have;
      logic [csch_pkg::SH_W-1:0] ch;
      logic [csch_pkg::VC_IDX_W-1:0] v;
      logic [csch_pkg::VC_IDX_W-1:0] f;
      logic [csch_pkg::VC_IDX_W-1:0] b;
      logic [csch_pkg::VC_IDX_W-1:0] h;
      logic [csch_pkg::SH_W-1:0] s;
      elig = '0;
      tied = '0;
      best = '1;
      found = 1'b0;
      have = 1'b0;
      ch = '0;
      v = '0;
      f = '0;
      b = '0;
      h = '0;
      s = '0;
      next_x = x; next_y = y; next_pi = pi; next_pm = pm;
      next_c = c; next_p = p; next_pp = pp; next_pc = pc; next_prio = prio;
      next_en = en; next_act = act; next_rr = rr; next_scan = scan_flags;
      next_spe_a = spe_a; next_spe_u = spe_u; next_spe_vc = spe_vc;
      next_tail = tail; next_fwd = fwd; next_bwd = bwd;
      next_vc_act = vc_act; next_vc_sh = vc_sh;
      next_cmd_ready = !pre_tick;
      next_rvalid = 1'b0;
      next_rdata = acc_rdata;
      next_sel_valid = 1'b0;
      next_sel_idle = 1'b0;
      next_sel_vc = sel_vc;
      next_sel_shaper = sel_shaper;
      if (tick)
      begin
         // ---------------------------------------------
         // once per pass: buckets, selection, service
         // ---------------------------------------------
         for (int i = 0; i < N; i++)
         begin
            elig[i] = all_shapers_on && en[i] && act[i] && (c[i] != '0)
                      && (p[i] == '0);
            if (all_shapers_on && en[i])
            begin
               if ((x[i] >= y[i]) && (c[i] < pc[i]))
                  next_c[i] = c[i] + C_ONE;
               if (x[i] == y[i])
               begin
                  next_x[i] = pi[i];
                  next_y[i] = pm[i];
               end
               else if (x[i] > y[i])
               begin
                  next_x[i] = x[i] + pi[i];
                  next_y[i] = y[i] + pm[i];
               end
               else
                  next_x[i] = x[i] + pi[i];
            end
            if (p[i] != '0)
               next_p[i] = p[i] - C_ONE;
            if (scan_flags[i] && !have)
            begin
               have = 1'b1;
               ch = csch_pkg::SH_W'(i);
            end
         end
         if (!have)
         begin
            for (int i = 0; i < N; i++)
               if (elig[i] && prio[i] < best)
                  best = prio[i];
            for (int i = 0; i < N; i++)
               tied[i] = elig[i] && (prio[i] == best);
            for (int i = 0; i < N; i++)
               if (tied[i] && !rr[i] && !found)
               begin
                  found = 1'b1;
                  ch = csch_pkg::SH_W'(i);
               end
            // every tied shaper has had its turn: start a new round
            if (!found)
               for (int i = N - 1; i >= 0; i--)
                  if (tied[i])
                  begin
                     found = 1'b1;
                     ch = csch_pkg::SH_W'(i);
                     next_rr[i] = 1'b0;
                  end
            if (found)
            begin
               have = 1'b1;
               next_rr[ch] = 1'b1;
               next_scan[ch] = 1'b1;
               next_p[ch] = pp[ch];
            end
         end
         if (have)
         begin
            next_sel_shaper = ch;
            v = spe_vc[ch][csch_pkg::VC_IDX_W-1:0];
            if (spe_u[ch])
            begin
               // generator shaper: one unassigned cell per scan
               next_sel_idle = 1'b1;
               next_scan[ch] = 1'b0;
               next_c[ch] = next_c[ch] - C_ONE;
            end
            else
            begin
               next_sel_valid = 1'b1;
               next_sel_vc = spe_vc[ch];
               next_spe_vc[ch] = csch_pkg::VC_W'(fwd[v]);
               if (v == tail[ch])
               begin
                  next_scan[ch] = 1'b0;
                  next_c[ch] = next_c[ch] - C_ONE;
               end
            end
         end
         else
            next_sel_idle = 1'b1;
      end
      else
      begin
         // ---------------------------------------------
         // commands, taken only outside the tick cycle
         // ---------------------------------------------
         if (done_valid && vc_act[done_vc[csch_pkg::VC_IDX_W-1:0]])
         begin
            v = done_vc[csch_pkg::VC_IDX_W-1:0];
            s = vc_sh[v];
            f = fwd[v];
            b = bwd[v];
            next_vc_act[v] = 1'b0;
            if (f == v)
            begin
               next_act[s] = 1'b0;
               next_spe_a[s] = 1'b0;
               next_spe_vc[s] = '0;
               next_scan[s] = 1'b0;
            end
            else
            begin
               next_fwd[b] = f;
               next_bwd[f] = b;
               if (tail[s] == v)
                  next_tail[s] = b;
               if (spe_vc[s][csch_pkg::VC_IDX_W-1:0] == v)
                  next_spe_vc[s] = csch_pkg::VC_W'(f);
            end
         end
         else if (go_valid && !vc_act[go_vc[csch_pkg::VC_IDX_W-1:0]])
         begin
            v = go_vc[csch_pkg::VC_IDX_W-1:0];
            s = go_shaper;
            next_vc_sh[v] = s;
            next_vc_act[v] = 1'b1;
            if (!spe_a[s])
            begin
               next_fwd[v] = v;
               next_bwd[v] = v;
               next_tail[s] = v;
               next_spe_vc[s] = csch_pkg::VC_W'(v);
               next_act[s] = 1'b1;
               next_spe_a[s] = 1'b1;
            end
            else
            begin
               h = fwd[tail[s]];
               next_fwd[tail[s]] = v;
               next_bwd[v] = tail[s];
               next_fwd[v] = h;
               next_bwd[h] = v;
               next_tail[s] = v;
            end
         end
         if (acc_valid)
         begin
            if (acc_write)
            begin
               next_spe_a[acc_index] = acc_wdata[csch_pkg::SPE_ACT_BIT];
               next_spe_u[acc_index] = acc_wdata[csch_pkg::SPE_UCG_BIT];
               next_spe_vc[acc_index] = acc_wdata[csch_pkg::SPE_VC_MSB:0];
            end
            else
            begin
               next_rdata = csch_pkg::SPE_RESET;
               next_rdata[csch_pkg::SPE_ACT_BIT] = spe_a[acc_index];
               next_rdata[csch_pkg::SPE_UCG_BIT] = spe_u[acc_index];
               next_rdata[csch_pkg::SPE_VC_MSB:0] = spe_vc[acc_index];
               next_rvalid = 1'b1;
            end
         end
         if (prm_valid)
            unique case (prm_field)
               csch_pkg::FLD_I: next_pi[prm_shaper] = prm_wdata;
               csch_pkg::FLD_M: next_pm[prm_shaper] = prm_wdata;
               csch_pkg::FLD_P: next_pp[prm_shaper] = prm_wdata[csch_pkg::CNT_W-1:0];
               csch_pkg::FLD_C: next_pc[prm_shaper] = prm_wdata[csch_pkg::CNT_W-1:0];
               csch_pkg::FLD_PRIO:
                  next_prio[prm_shaper] = prm_wdata[csch_pkg::PRIO_W-1:0];
               csch_pkg::FLD_CTRL:
               begin
                  next_en[prm_shaper] = prm_wdata[csch_pkg::CTRL_EN_BIT];
                  next_act[prm_shaper] = prm_wdata[csch_pkg::CTRL_ACT_BIT];
               end
               default: next_en = en; // unused selector codes are ignored
            endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < N; i++)
         begin
            x[i] <= '0; y[i] <= '0; pi[i] <= '0; pm[i] <= '0;
            c[i] <= '0; p[i] <= '0; pp[i] <= '0; pc[i] <= '0; prio[i] <= '0;
            spe_vc[i] <= '0; tail[i] <= '0;
         end
         for (int j = 0; j < NV; j++)
         begin
            fwd[j] <= '0; bwd[j] <= '0; vc_sh[j] <= '0;
         end
         en <= '0; act <= '0; rr <= '0; scan_flags <= '0;
         spe_a <= '0; spe_u <= '0; vc_act <= '0;
         cmd_ready <= 1'b0; acc_rvalid <= 1'b0; acc_rdata <= '0;
         sel_valid <= 1'b0; sel_idle <= 1'b0; sel_vc <= '0; sel_shaper <= '0;
      end
      else
      begin
         x <= next_x; y <= next_y; pi <= next_pi; pm <= next_pm;
         c <= next_c; p <= next_p; pp <= next_pp; pc <= next_pc; prio <= next_prio;
         spe_vc <= next_spe_vc; tail <= next_tail;
         fwd <= next_fwd; bwd <= next_bwd; vc_sh <= next_vc_sh;
         en <= next_en; act <= next_act; rr <= next_rr; scan_flags <= next_scan;
         spe_a <= next_spe_a; spe_u <= next_spe_u; vc_act <= next_vc_act;
         cmd_ready <= next_cmd_ready; acc_rvalid <= next_rvalid; acc_rdata <= next_rdata;
         sel_valid <= next_sel_valid; sel_idle <= next_sel_idle;
         sel_vc <= next_sel_vc; sel_shaper <= next_sel_shaper;
      end
   end
endmodule

// [verification/csch_checker.sv]
// port checks for the shaper scheduler
`timescale 1ns/1ps
module csch_checker (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic all_shapers_on, // global enable
   input wire logic acc_valid, // access strobe
   input wire logic acc_write, // access direction
   input wire logic cmd_ready, // commands taken
   input wire logic [31:0] acc_rdata, // entry read data
   input wire logic acc_rvalid, // read data valid
   input wire logic sel_valid, // data cell slot
   input wire logic sel_idle, // idle cell slot
   input wire logic [15:0] scan_flags // scan flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ---------------------------------------------
   // slot and read sequences
   // ---------------------------------------------
   sequence slot_s;
      sel_valid || sel_idle;
   endsequence
   sequence read_s;
      acc_valid && !acc_write && cmd_ready;
   endsequence
   sequence gap_s;
      (!sel_valid && !sel_idle) [*8];
   endsequence
   a_slot_period: assert property (slot_s |-> ##36 slot_s)
      else $error("slot spacing differs from one pass");
   a_slot_gap: assert property (slot_s |=> gap_s)
      else $error("second slot inside a pass");
   a_slot_single: assert property (!(sel_valid && sel_idle))
      else $error("data and idle cell in one slot");
   a_tick_refuses: assert property (slot_s |-> $past(cmd_ready) == 1'b0)
      else $error("commands taken in the tick cycle");
   a_read_answer: assert property (read_s |=> acc_rvalid)
      else $error("read without answer");
   a_entry_zeros: assert property (acc_rvalid |-> acc_rdata[29:15] == 15'h0000)
      else $error("reserved entry bits not zero");
   a_empty_vc: assert property (acc_rvalid && !acc_rdata[31] |-> acc_rdata[14:0] == 15'h0000)
      else $error("empty shaper with nonzero VC");
   a_scan_single: assert property ($onehot0(scan_flags))
      else $error("more than one shaper scanning");
   a_scan_at_slot: assert property (|(scan_flags & ~$past(scan_flags)) |-> slot_s)
      else $error("scan entered outside a slot");
   a_scan_needs_on: assert property (|(scan_flags & ~$past(scan_flags)) |-> $past(all_shapers_on))
      else $error("scan entered while shapers off");
endmodule
bind csch_scheduler csch_checker i_chk (.clk(clk), .srst(srst), .all_shapers_on(all_shapers_on),
   .acc_valid(acc_valid), .acc_write(acc_write), .cmd_ready(cmd_ready), .acc_rdata(acc_rdata),
   .acc_rvalid(acc_rvalid), .sel_valid(sel_valid), .sel_idle(sel_idle), .scan_flags(scan_flags));

// [verification/csch_txm_model.sv]
// transmit cell machine model: a VC goes idle after CELLS data cells
`timescale 1ns/1ps
module csch_txm_model #(
   parameter int CELLS = 2
) (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic sel_valid, // data cell slot
   input wire logic [14:0] sel_vc, // VC served
   output logic done_valid, // descriptor vacant, data read
   output logic [14:0] done_vc // VC gone idle
);
   int sent [64];
   initial
   begin
      done_valid = 1'b0;
      done_vc = 15'h0000;
   end
   always @(posedge clk)
   begin
      done_valid <= 1'b0;
      // released bus wobbles so a stale VC never looks valid
      done_vc <= ~done_vc;
      if (srst)
         sent <= '{default: 0};
      else if (sel_valid === 1'b1)
      begin
         sent[sel_vc[5:0]] <= sent[sel_vc[5:0]] + 1;
         if (sent[sel_vc[5:0]] + 1 == CELLS)
         begin
            done_valid <= 1'b1;
            done_vc <= sel_vc;
            sent[sel_vc[5:0]] <= 0;
         end
      end
   end
endmodule

// [verification/csch_scheduler_bench.sv]
// self-checking bench for the shaper scheduler
`timescale 1ns/1ps
module csch_scheduler_bench;
   typedef struct packed {logic [14:0] vc; logic [3:0] sh; logic [31:0] exp;} csch_row_t;
   localparam csch_row_t ROWS [3] = '{'{15'h0005, 4'h3, 32'h8000_0005},
      '{15'h0005, 4'h3, 32'h8000_0005}, '{15'h0009, 4'h3, 32'h8000_0005}};
   // I, M, P, C, priority, ctrl
   // ctrl sets A with E: writing A as 0 would leave the VCs already linked unserved
   localparam logic [31:0] PRM [6] = '{32'h1, 32'h1, 32'h0, 32'h2, 32'h0, 32'h3};
   localparam logic [14:0] EXP_VC [4] = '{15'h0005, 15'h0009, 15'h0005, 15'h0009};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic all_shapers_on = 1'b0;
   logic go_valid = 1'b0;
   logic acc_valid = 1'b0;
   logic acc_write = 1'b0;
   logic prm_valid = 1'b0;
   logic [3:0] idx = 4'h0;
   logic [2:0] prm_field = 3'h0;
   logic [31:0] wd = 32'h0;
   wire done_valid, cmd_ready, acc_rvalid, sel_valid, sel_idle;
   wire [14:0] done_vc, sel_vc;
   wire [31:0] acc_rdata;
   wire [3:0] sel_shaper;
   wire [15:0] scan_flags;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int gen_seen = 0;
   logic [14:0] data_q [$];
   always #50 clk = ~clk;
   csch_scheduler i_dut (.clk(clk), .srst(srst), .all_shapers_on(all_shapers_on),
      .go_valid(go_valid), .go_vc(wd[14:0]), .go_shaper(idx), .done_valid(done_valid),
      .done_vc(done_vc), .acc_valid(acc_valid), .acc_write(acc_write), .acc_index(idx),
      .acc_wdata(wd), .prm_valid(prm_valid), .prm_shaper(idx), .prm_field(prm_field),
      .prm_wdata(wd), .cmd_ready(cmd_ready), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .sel_valid(sel_valid), .sel_idle(sel_idle), .sel_vc(sel_vc), .sel_shaper(sel_shaper),
      .scan_flags(scan_flags));
   csch_txm_model #(.CELLS(2)) i_txm (.clk(clk), .srst(srst), .sel_valid(sel_valid),
      .sel_vc(sel_vc), .done_valid(done_valid), .done_vc(done_vc));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // re-presents the command while the tick cycle refuses it
   task automatic cmd(input logic [1:0] k, input logic [3:0] sh, input logic [2:0] f,
      input logic [31:0] d);
      logic ok;
      ok = 1'b0;
      while (!ok)
      begin
         go_valid <= (k == 2'h0);
         acc_valid <= (k == 2'h1 || k == 2'h2);
         acc_write <= (k == 2'h2);
         prm_valid <= (k == 2'h3);
         idx <= sh;
         prm_field <= f;
         wd <= d;
         @(posedge clk);
         ok = (cmd_ready === 1'b1);
      end
      go_valid <= 1'b0;
      acc_valid <= 1'b0;
      prm_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] sh, input logic [31:0] exp);
      cmd(2'h1, sh, 3'h0, 32'h0);
      chk({31'h0, acc_rvalid}, 32'h1);
      chk(acc_rdata, exp);
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (sel_valid === 1'b1)
         data_q.push_back(sel_vc);
      if (sel_idle === 1'b1 && sel_shaper === 4'h7)
         gen_seen++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({13'h0000, sel_valid, sel_idle, acc_rvalid, scan_flags}, 32'h0);
      for (int i = 0; i < 16; i++)
         rd(i[3:0], 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         cmd(2'h0, ROWS[i].sh, 3'h0, {17'h0, ROWS[i].vc});
         rd(ROWS[i].sh, ROWS[i].exp);
      end
      // go presented in the tick cycle must be dropped
      for (int k = 0; k < 40 && !(sel_valid === 1'b1 || sel_idle === 1'b1); k++)
         @(posedge clk);
      repeat (34) @(posedge clk);
      idx <= 4'h4;
      wd <= 32'h0000_000C;
      go_valid <= 1'b1;
      @(posedge clk);
      chk({31'h0, cmd_ready}, 32'h0);
      go_valid <= 1'b0;
      @(posedge clk);
      rd(4'h4, 32'h0);
      all_shapers_on <= 1'b1;
      for (int f = 0; f < 6; f++)
         cmd(2'h3, 4'h3, f[2:0], PRM[f]);
      for (int k = 0; k < 3000 && data_q.size() < 4; k++)
         @(posedge clk);
      repeat (80) @(posedge clk);
      chk(data_q.size(), 32'h4);
      for (int i = 0; i < 4; i++)
         chk({17'h0, data_q[i]}, {17'h0, EXP_VC[i]});
      chk({16'h0, scan_flags}, 32'h0);
      rd(4'h3, 32'h0);
      // no shaper active now: the next slot must be an idle cell
      for (int k = 0; k < 40 && !(sel_valid === 1'b1 || sel_idle === 1'b1); k++)
         @(posedge clk);
      chk({30'h0, sel_valid, sel_idle}, 32'h1);
      cmd(2'h2, 4'h7, 3'h0, 32'hC000_0000);
      rd(4'h7, 32'hC000_0000);
      for (int f = 0; f < 6; f++)
         cmd(2'h3, 4'h7, f[2:0], (f == 5) ? 32'h3 : PRM[f]);
      for (int k = 0; k < 400 && gen_seen == 0; k++)
         @(posedge clk);
      chk({31'h0, gen_seen != 0}, 32'h1);
      print_verdict();
   end
endmodule
